// ==== design/plc_alarm_gen.sv ====
`timescale 1ns/1ps
`default_nettype none

// Produces the alarm bit stream. The framed pattern carries alternating
// ones and zeros in payload slots and the framer's own overhead bits in
// overhead slots; the unframed pattern is all ones.
module plc_alarm_gen (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_advance,
    input wire logic i_framed,
    input wire logic i_oh_slot,
    input wire logic i_oh_bit,
    output logic o_bit
);
    logic phase_q;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            phase_q <= 1'b1;
        else if (i_advance && !i_oh_slot)
            phase_q <= ~phase_q;
    end

    assign o_bit = !i_framed ? 1'b1 : (i_oh_slot ? i_oh_bit : phase_q);
endmodule

`default_nettype wire

// ==== design/plc_params.svh ====
// Contract
// - Alarm select chooses automatic, ones, alarm, none.
// - DS3 framing sends framed alarm, else ones.
// - Selected alarm overrides framer, even in loopback.
// - Tester enable runs tester, else clocks stopped.
// - Receive data always reaches the cell processor.
// - Link controllers follow PLCP select in PLCP.
// - Port strobe rising edge injects errors.
// - Error source picks port or global strobe.
// - Latch source picks port or global strobe.
// - Latch rising edge captures counts, restarts counters.
// - Latch done clears when strobe returns low.
// - Power-down stops port clocks; reads one.
// - Datapath reset forces defaults, held 100ns.
// - Port reset forces all but itself, 100ns.
// - Effective reset ORs bit, global, pin.
// - Output enable low forces line pins low.
// - Verify count six or eight cells.
// - Line code unipolar, zero-suppressed or AMI.
// - Delineator location chosen only in PLCP modes.
// - Cell or packet select in packet bus.
// - Six-bit framing mode resets to DS3 C-bit.
// - Framing mode encoding with two reserved codes.
`ifndef PLC_PARAMS_SVH
`define PLC_PARAMS_SVH

`define PLC_IDX_ALARM_RESET 10'h040
`define PLC_IDX_LINE_MODE 10'h042
`define PLC_IDX_STATUS 10'h052
`define PLC_CR1_MASK 16'hffdf
`define PLC_CR1_RESET 16'h0006
`define PLC_CR2_MASK 16'h8cff
`define PLC_CR2_RESET 16'h0000
`define PLC_ALARM_SEL_LSB 10
`define PLC_TESTER_EN_BIT 9
`define PLC_LINK_SRC_BIT 8
`define PLC_ERR_STROBE_BIT 7
`define PLC_ERR_SRC_BIT 6
`define PLC_LATCH_SRC_BIT 4
`define PLC_LATCH_STROBE_BIT 3
`define PLC_POWER_DOWN_BIT 2
`define PLC_DP_RESET_BIT 1
`define PLC_PORT_RESET_BIT 0
`define PLC_TX_EN_BIT 15
`define PLC_VERIFY8_BIT 11
`define PLC_UNIPOLAR_BIT 10
`define PLC_DELIN_LOC_BIT 7
`define PLC_CELL_SEL_BIT 6
`define PLC_ALARM_AUTO 2'h0
`define PLC_ALARM_ONES 2'h1
`define PLC_ALARM_SEND 2'h2
`define PLC_VERIFY_SIX 4'h6
`define PLC_VERIFY_EIGHT 4'h8
`define PLC_FM_DS3_CBIT 6'h00
`define PLC_FM_DS3_M23 6'h08
`define PLC_FM_E3_G751 6'h10
`define PLC_FM_RSVD_A 6'h1c
`define PLC_FM_RSVD_B 6'h1d
`define PLC_RESET_HOLD_NS 100
`define PLC_MCLK_PERIOD_NS 25
`define PLC_RESET_HOLD_CYC ((`PLC_RESET_HOLD_NS + `PLC_MCLK_PERIOD_NS - 1) / `PLC_MCLK_PERIOD_NS)

`endif

// ==== design/plc_pkg.sv ====
package plc_pkg;

    typedef enum logic [1:0] {
        PLC_CODE_ZS = 2'h0,
        PLC_CODE_AMI = 2'h1,
        PLC_CODE_UNI = 2'h3
    } plc_line_code_t;

    typedef struct packed {
        logic port_clk_en;
        logic tester_clk_en;
        logic payload_from_tester;
        logic rx_to_processor;
        logic link_ctrl_plcp;
        logic delineate_in_plcp;
        logic cell_processing;
        logic plcp_mode;
        logic datapath_reset;
        logic port_reset;
        logic [3:0] verify_count;
        plc_line_code_t line_code;
        logic [5:0] framing_mode;
        logic framing_reserved;
    } plc_ctrl_t;

    typedef struct packed {
        logic clk;
        logic pos;
        logic neg;
    } plc_line_t;

endpackage

// ==== design/plc_port_ctrl.sv ====
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "plc_params.svh"

module plc_port_ctrl
    import plc_pkg::*;
(
    input wire logic I_MCLK,
    input wire logic I_RESET,
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [11:0] I_WB_ADR,
    input wire logic [31:0] I_WB_DAT,
    input wire logic [3:0] I_WB_SEL,
    output logic [31:0] O_WB_DAT,
    output logic O_WB_ACK,
    input wire logic I_HW_RESET_N,
    input wire logic I_GLOBAL_RESET,
    input wire logic I_GLOBAL_ERR_STROBE,
    input wire logic I_GLOBAL_LATCH_STROBE,
    input wire logic [2:0] I_LOOPBACK_MODE_FIELD,
    input wire logic I_TX_ZERO_SUPPRESS_DISABLE,
    input wire logic I_RX_ZERO_SUPPRESS_DISABLE,
    input wire logic I_PACKET_BUS_MODE,
    input wire logic I_COUNTS_CAPTURED,
    input wire plc_line_t I_FRAMER_LINE,
    input wire logic I_FRAMER_OH_SLOT,
    output plc_ctrl_t O_CTRL,
    output plc_line_t O_TX_LINE,
    output logic O_ERROR_INSERT,
    output logic O_COUNTER_LATCH
);
    logic [15:0] cr1_q;
    logic [15:0] cr2_q;
    logic hw_rst_n_meta_q;
    logic hw_rst_n_sync_q;
    logic eff_reset;
    logic [3:0] dp_hold_q;
    logic dp_reset;
    logic latch_done_q;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic ack_q;
    logic req;
    logic [9:0] idx;
    logic wr_cr1;
    logic wr_cr2;
    logic [15:0] wmask;
    logic [1:0] alarm_sel;
    logic diag_loopback;
    logic [5:0] fm;
    logic plcp_mode;
    logic ds3_framed;
    logic alarm_on;
    logic alarm_bit;
    logic err_src_level;
    logic err_rise;
    logic latch_src_level;
    logic latch_rise;
    logic ami_pol_q;
    plc_ctrl_t ctrl_d;
    plc_ctrl_t ctrl_q;
    plc_line_t line_d;
    plc_line_t line_q;

    // Hardware reset pin comes from outside the clock domain.
    always_ff @(posedge I_MCLK)
    begin
        if (I_RESET)
        begin
            hw_rst_n_meta_q <= 1'b0;
            hw_rst_n_sync_q <= 1'b0;
        end
        else
        begin
            hw_rst_n_meta_q <= I_HW_RESET_N;
            hw_rst_n_sync_q <= hw_rst_n_meta_q;
        end
    end

    assign eff_reset = I_RESET | cr1_q[`PLC_PORT_RESET_BIT] | I_GLOBAL_RESET | ~hw_rst_n_sync_q;

    // Classic Wishbone slave: one wait cycle, ack drops after one cycle.
    assign req = I_WB_CYC & I_WB_STB & ~ack_q;
    assign idx = I_WB_ADR[11:2];
    assign wmask = {{8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};
    assign wr_cr1 = req & I_WB_WE & (idx == `PLC_IDX_ALARM_RESET);
    assign wr_cr2 = req & I_WB_WE & (idx == `PLC_IDX_LINE_MODE);

    always_ff @(posedge I_MCLK)
    begin
        if (I_RESET)
            ack_q <= 1'b0;
        else
            ack_q <= req;
    end

    // The port reset bit has its own reset term: it is not cleared by itself.
    always_ff @(posedge I_MCLK)
    begin
        if (I_RESET || I_GLOBAL_RESET || !hw_rst_n_sync_q)
            cr1_q[`PLC_PORT_RESET_BIT] <= 1'b0;
        else if (wr_cr1 && I_WB_SEL[0])
            cr1_q[`PLC_PORT_RESET_BIT] <= I_WB_DAT[`PLC_PORT_RESET_BIT];
        if (eff_reset)
            cr1_q[15:1] <= 15'(`PLC_CR1_RESET >> 1);
        else if (wr_cr1)
            cr1_q[15:1] <= ((cr1_q[15:1] & ~wmask[15:1]) | (I_WB_DAT[15:1] & wmask[15:1]))
                & 15'(`PLC_CR1_MASK >> 1);
    end

    always_ff @(posedge I_MCLK)
    begin
        if (eff_reset)
            cr2_q <= `PLC_CR2_RESET;
        else if (wr_cr2)
            cr2_q <= ((cr2_q & ~wmask) | (I_WB_DAT[15:0] & wmask)) & `PLC_CR2_MASK;
    end

    // Datapath reset lasts at least the minimum hold after the bit clears.
    always_ff @(posedge I_MCLK)
    begin
        if (eff_reset || cr1_q[`PLC_DP_RESET_BIT])
            dp_hold_q <= 4'(`PLC_RESET_HOLD_CYC);
        else if (dp_hold_q != 4'h0)
            dp_hold_q <= dp_hold_q - 4'h1;
    end

    assign dp_reset = eff_reset | cr1_q[`PLC_DP_RESET_BIT] | (dp_hold_q != 4'h0);

    // Strobe source selection and edge detection.
    assign err_src_level = cr1_q[`PLC_ERR_SRC_BIT] ? I_GLOBAL_ERR_STROBE : cr1_q[`PLC_ERR_STROBE_BIT];
    assign latch_src_level = cr1_q[`PLC_LATCH_SRC_BIT] ? I_GLOBAL_LATCH_STROBE
        : cr1_q[`PLC_LATCH_STROBE_BIT];

    plc_rise_det #(.RESET_LEVEL(1'b0)) u_err_rise (
        .i_clk(I_MCLK),
        .i_rst(eff_reset),
        .i_level(err_src_level),
        .o_rise(err_rise)
    );

    plc_rise_det #(.RESET_LEVEL(1'b0)) u_latch_rise (
        .i_clk(I_MCLK),
        .i_rst(eff_reset),
        .i_level(latch_src_level),
        .o_rise(latch_rise)
    );

    always_ff @(posedge I_MCLK)
    begin
        if (eff_reset || cr1_q[`PLC_POWER_DOWN_BIT])
        begin
            O_ERROR_INSERT <= 1'b0;
            O_COUNTER_LATCH <= 1'b0;
        end
        else
        begin
            O_ERROR_INSERT <= err_rise;
            O_COUNTER_LATCH <= latch_rise;
        end
    end

    // Latch done sets once counters report capture while the port strobe is selected and high; while the strobe is low the clear wins.
    always_ff @(posedge I_MCLK)
    begin
        if (eff_reset)
            latch_done_q <= 1'b0;
        else if (I_COUNTS_CAPTURED && !cr1_q[`PLC_LATCH_SRC_BIT] && cr1_q[`PLC_LATCH_STROBE_BIT])
            latch_done_q <= 1'b1;
        else if (!cr1_q[`PLC_LATCH_STROBE_BIT])
            latch_done_q <= 1'b0;
    end

    // Mode decode.
    assign fm = cr2_q[5:0];
    assign plcp_mode = ~fm[5] & fm[2] & ~fm[1];
    assign ds3_framed = ~fm[5] & ~fm[4];
    assign diag_loopback = I_LOOPBACK_MODE_FIELD[2];
    assign alarm_sel = cr1_q[`PLC_ALARM_SEL_LSB +: 2];

    always_comb
    begin
        case (alarm_sel)
            `PLC_ALARM_AUTO: alarm_on = diag_loopback;
            `PLC_ALARM_ONES: alarm_on = 1'b1;
            `PLC_ALARM_SEND: alarm_on = 1'b1;
            default: alarm_on = 1'b0;
        endcase
    end

    plc_alarm_gen u_alarm (
        .i_clk(I_MCLK),
        .i_rst(dp_reset),
        .i_advance(I_FRAMER_LINE.clk & ~line_q.clk),
        .i_framed(ds3_framed && alarm_sel != `PLC_ALARM_ONES),
        .i_oh_slot(I_FRAMER_OH_SLOT),
        .i_oh_bit(I_FRAMER_LINE.pos),
        .o_bit(alarm_bit)
    );

    always_comb
    begin
        ctrl_d = '0;
        ctrl_d.port_clk_en = ~cr1_q[`PLC_POWER_DOWN_BIT];
        ctrl_d.tester_clk_en = cr1_q[`PLC_TESTER_EN_BIT] & ~cr1_q[`PLC_POWER_DOWN_BIT];
        ctrl_d.payload_from_tester = cr1_q[`PLC_TESTER_EN_BIT];
        ctrl_d.rx_to_processor = 1'b1;
        ctrl_d.link_ctrl_plcp = plcp_mode & cr1_q[`PLC_LINK_SRC_BIT];
        ctrl_d.delineate_in_plcp = plcp_mode & cr2_q[`PLC_DELIN_LOC_BIT];
        ctrl_d.cell_processing = I_PACKET_BUS_MODE ? (plcp_mode | cr2_q[`PLC_CELL_SEL_BIT]) : 1'b1;
        ctrl_d.plcp_mode = plcp_mode;
        ctrl_d.datapath_reset = dp_reset;
        ctrl_d.port_reset = eff_reset;
        ctrl_d.verify_count = cr2_q[`PLC_VERIFY8_BIT] ? `PLC_VERIFY_EIGHT : `PLC_VERIFY_SIX;
        if (cr2_q[`PLC_UNIPOLAR_BIT])
            ctrl_d.line_code = PLC_CODE_UNI;
        else if (I_TX_ZERO_SUPPRESS_DISABLE & I_RX_ZERO_SUPPRESS_DISABLE)
            ctrl_d.line_code = PLC_CODE_AMI;
        else
            ctrl_d.line_code = PLC_CODE_ZS;
        ctrl_d.framing_mode = fm;
        ctrl_d.framing_reserved = (fm == `PLC_FM_RSVD_A) || (fm == `PLC_FM_RSVD_B);
    end

    always_ff @(posedge I_MCLK)
    begin
        if (I_RESET)
            ctrl_q <= '0;
        else
            ctrl_q <= ctrl_d;
    end

    assign O_CTRL = ctrl_q;

    // Alarm marks alternate polarity unless the line is unipolar.
    always_ff @(posedge I_MCLK)
    begin
        if (dp_reset)
            ami_pol_q <= 1'b0;
        else if (alarm_on && alarm_bit && I_FRAMER_LINE.clk && !line_q.clk)
            ami_pol_q <= ~ami_pol_q;
    end

    always_comb
    begin
        line_d.clk = I_FRAMER_LINE.clk;
        if (alarm_on)
        begin
            line_d.pos = alarm_bit & (cr2_q[`PLC_UNIPOLAR_BIT] | ~ami_pol_q);
            line_d.neg = alarm_bit & ~cr2_q[`PLC_UNIPOLAR_BIT] & ami_pol_q;
        end
        else
        begin
            line_d.pos = I_FRAMER_LINE.pos;
            line_d.neg = I_FRAMER_LINE.neg;
        end
        if (!cr2_q[`PLC_TX_EN_BIT] || cr1_q[`PLC_POWER_DOWN_BIT])
            line_d = '0;
    end

    always_ff @(posedge I_MCLK)
    begin
        if (dp_reset)
            line_q <= '0;
        else
            line_q <= line_d;
    end

    assign O_TX_LINE = line_q;

    always_comb
    begin
        rdata_d = 32'h0000_0000;
        case (idx)
            `PLC_IDX_ALARM_RESET: rdata_d[15:0] = cr1_q;
            `PLC_IDX_LINE_MODE: rdata_d[15:0] = cr2_q;
            `PLC_IDX_STATUS: rdata_d[3:0] = {dp_reset, plcp_mode, eff_reset, latch_done_q};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge I_MCLK)
    begin
        if (I_RESET)
            rdata_q <= 32'h0000_0000;
        else if (req && !I_WB_WE)
            rdata_q <= rdata_d;
    end

    assign O_WB_DAT = rdata_q;
    assign O_WB_ACK = ack_q;

    property p_tx_gate;
        @(posedge I_MCLK) disable iff (I_RESET)
        !cr2_q[`PLC_TX_EN_BIT] |=> (O_TX_LINE == '0);
    endproperty
    a_tx_gate: assert property (p_tx_gate) else $error("line pins not low while disabled");

    property p_eff_reset;
        @(posedge I_MCLK) disable iff (I_RESET)
        (I_GLOBAL_RESET || cr1_q[`PLC_PORT_RESET_BIT]) |=> (cr1_q[2:1] == 2'h3 && cr2_q == 16'h0000);
    endproperty
    a_eff_reset: assert property (p_eff_reset) else $error("port reset left controls set");

    property p_dp_hold;
        @(posedge I_MCLK) disable iff (I_RESET)
        $fell(cr1_q[`PLC_DP_RESET_BIT]) && !eff_reset |-> dp_reset [*4];
    endproperty
    a_dp_hold: assert property (p_dp_hold) else $error("datapath reset shorter than 100ns");

    property p_err_port;
        @(posedge I_MCLK) disable iff (I_RESET)
        !eff_reset && !cr1_q[`PLC_POWER_DOWN_BIT] && !cr1_q[`PLC_ERR_SRC_BIT]
            && $rose(cr1_q[`PLC_ERR_STROBE_BIT]) |=> O_ERROR_INSERT;
    endproperty
    a_err_port: assert property (p_err_port) else $error("error strobe edge not injected");

    property p_err_global;
        @(posedge I_MCLK) disable iff (I_RESET)
        O_ERROR_INSERT |-> $past(cr1_q[`PLC_ERR_SRC_BIT] ? I_GLOBAL_ERR_STROBE : cr1_q[`PLC_ERR_STROBE_BIT])
            && (!$past(err_src_level, 2) || $past(eff_reset, 2));
    endproperty
    a_err_global: assert property (p_err_global) else $error("error insert from wrong source");

    property p_latch;
        @(posedge I_MCLK) disable iff (I_RESET)
        !eff_reset && !cr1_q[`PLC_POWER_DOWN_BIT] && latch_rise |=> O_COUNTER_LATCH;
    endproperty
    a_latch: assert property (p_latch) else $error("counter latch pulse missing");

    property p_latch_done_clear;
        @(posedge I_MCLK) disable iff (I_RESET)
        !cr1_q[`PLC_LATCH_STROBE_BIT] && !I_COUNTS_CAPTURED |=> !latch_done_q;
    endproperty
    a_latch_done_clear: assert property (p_latch_done_clear) else $error("latch done not cleared");

    property p_alarm_ones;
        @(posedge I_MCLK) disable iff (I_RESET)
        alarm_sel == `PLC_ALARM_ONES && cr2_q[`PLC_TX_EN_BIT] && cr2_q[`PLC_UNIPOLAR_BIT]
            && !cr1_q[`PLC_POWER_DOWN_BIT] && !dp_reset |=> O_TX_LINE.pos && !O_TX_LINE.neg;
    endproperty
    a_alarm_ones: assert property (p_alarm_ones) else $error("all ones not sent");

    property p_verify;
        @(posedge I_MCLK) disable iff (I_RESET)
        !I_RESET |=> O_CTRL.verify_count == ($past(cr2_q[`PLC_VERIFY8_BIT]) ? 4'h8 : 4'h6);
    endproperty
    a_verify: assert property (p_verify) else $error("verify count wrong");

    property p_link_src;
        @(posedge I_MCLK) disable iff (I_RESET)
        !plcp_mode |=> !O_CTRL.link_ctrl_plcp && !O_CTRL.delineate_in_plcp;
    endproperty
    a_link_src: assert property (p_link_src) else $error("PLCP routing outside PLCP mode");

    property p_tester;
        @(posedge I_MCLK) disable iff (I_RESET)
        !I_RESET && !cr1_q[`PLC_TESTER_EN_BIT] |=> !O_CTRL.tester_clk_en && O_CTRL.rx_to_processor;
    endproperty
    a_tester: assert property (p_tester) else $error("tester clocks running while disabled");
endmodule

`default_nettype wire

// ==== design/plc_rise_det.sv ====
`timescale 1ns/1ps
`default_nettype none

// Turns a level into a one-cycle pulse on its low-to-high transition.
module plc_rise_det #(
    parameter bit RESET_LEVEL = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_level,
    output logic o_rise
);
    logic level_q;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            level_q <= RESET_LEVEL;
        else
            level_q <= i_level;
    end

    assign o_rise = i_level & ~level_q;
endmodule

`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "plc_params.svh"

module tb_top
    import plc_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [15:0] wdat = 16'h0000;
    logic [31:0] rdat;
    logic ack, einj, latch;
    logic hwn = 1'b1, grst = 1'b0, gerr = 1'b0, glat = 1'b0, cap = 1'b0;
    logic pkt = 1'b1, ohs = 1'b0, tzd = 1'b0, rzd = 1'b0;
    logic [2:0] lbk = 3'h0;
    plc_line_t fl = 3'h0;
    plc_ctrl_t ctrl;
    plc_line_t tx;
    int err_total = 0, num_checks = 0;
    logic [15:0] r, e, l, n;
    logic [5:0] fm;
    logic plcp;
    logic [16:0] lm [8] = '{17'h00000, 17'h00808, 17'h00410, 17'h10004,
                            17'h0001c, 17'h0001d, 17'h00020, 17'h00014};
    logic [31:0] rt [4] = '{32'h030000c4, 32'h01000080, 32'h00040040, 32'h00000004};

    always #12.5 clk = ~clk;

    plc_port_ctrl plc_port_ctrl_i (
        .I_MCLK(clk), .I_RESET(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
        .I_WB_ADR(adr), .I_WB_DAT({16'h0000, wdat}), .I_WB_SEL(4'h3), .O_WB_DAT(rdat),
        .O_WB_ACK(ack), .I_HW_RESET_N(hwn), .I_GLOBAL_RESET(grst), .I_GLOBAL_ERR_STROBE(gerr),
        .I_GLOBAL_LATCH_STROBE(glat), .I_LOOPBACK_MODE_FIELD(lbk),
        .I_TX_ZERO_SUPPRESS_DISABLE(tzd), .I_RX_ZERO_SUPPRESS_DISABLE(rzd),
        .I_PACKET_BUS_MODE(pkt), .I_COUNTS_CAPTURED(cap), .I_FRAMER_LINE(fl),
        .I_FRAMER_OH_SLOT(ohs), .O_CTRL(ctrl), .O_TX_LINE(tx), .O_ERROR_INSERT(einj),
        .O_COUNTER_LATCH(latch)
    );

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask

    // One classic cycle; the request stands until ack is sampled high.
    task automatic wb(input logic w, input logic [11:0] a, input logic [15:0] d);
        int k;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        k = 0;
        @(posedge clk);
        while (ack !== 1'b1 && k < 16)
        begin
            k++;
            @(posedge clk);
        end
        if (ack !== 1'b1)
            err_total++;
        r = rdat[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        wb(1'b1, a, d);
    endtask

    task automatic rd(input string what, input logic [11:0] a, input logic [15:0] exp);
        wb(1'b0, a, 16'h0000);
        chk(what, exp, r);
    endtask

    task automatic pulses(output logic [15:0] pe, output logic [15:0] pl);
        pe = 16'h0000;
        pl = 16'h0000;
        repeat (6)
        begin
            @(posedge clk);
            pe += einj;
            pl += latch;
        end
    endtask

    // Counts ones on the positive line while the framer clock runs.
    task automatic ones(output logic [15:0] cnt);
        cnt = 16'h0000;
        repeat (16)
        begin
            @(posedge clk);
            fl.clk <= ~fl.clk;
            cnt += tx.pos;
        end
    endtask

    task automatic endt(input string s);
        $display("test %s done", s);
    endtask

    task automatic final_report;
        $display("checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        tick(5);
        rst <= 1'b0;
        tick(5);
        rd("line mode", 12'h108, 16'h0000);
        rd("alarm ctl", 12'h100, 16'h0006);
        rd("unmapped", 12'h1fc, 16'h0000);
        chk("dp reset", 16'h1, {15'h0, ctrl.datapath_reset});
        chk("clk en", 16'h0, {15'h0, ctrl.port_clk_en});
        wr(12'h100, 16'h0000);
        tick(1);
        chk("dp hold", 16'h1, {15'h0, ctrl.datapath_reset});
        tick(6);
        chk("dp off", 16'h0, {15'h0, ctrl.datapath_reset});
        chk("clk on", 16'h1, {15'h0, ctrl.port_clk_en});
        wr(12'h108, 16'hffff);
        rd("mode mask", 12'h108, 16'h8cff);
        wr(12'h100, 16'hffde);
        rd("ctl mask", 12'h100, 16'hffde);
        wr(12'h100, 16'h0000);
        tick(6);
        endt("reset");
        for (int i = 0; i < 8; i++)
        begin
            tzd <= lm[i][16];
            rzd <= lm[i][16];
            wr(12'h108, lm[i][15:0]);
            tick(2);
            fm = lm[i][5:0];
            e = {lm[i][11] ? `PLC_VERIFY_EIGHT : `PLC_VERIFY_SIX,
                 lm[i][10] ? PLC_CODE_UNI : (lm[i][16] ? PLC_CODE_AMI : PLC_CODE_ZS),
                 fm == `PLC_FM_RSVD_A || fm == `PLC_FM_RSVD_B, !fm[5] && fm[2:1] == 2'b10, fm, 2'b00};
            chk("mode ctrl", e, {ctrl.verify_count, ctrl.line_code, ctrl.framing_reserved,
                ctrl.plcp_mode, ctrl.framing_mode, 2'b00});
        end
        tzd <= 1'b0;
        rzd <= 1'b0;
        endt("line mode");
        for (int i = 0; i < 4; i++)
        begin
            pkt <= i != 1;
            wr(12'h100, rt[i][31:16]);
            wr(12'h108, rt[i][15:0]);
            tick(2);
            plcp = !rt[i][5] && rt[i][2:1] == 2'b10;
            e = {9'h0, plcp & rt[i][24], plcp & rt[i][7], plcp | rt[i][6] | (i == 1),
                 rt[i][25] & !rt[i][18], rt[i][25], 1'b1, !rt[i][18]};
            chk("routing", e, {9'h0, ctrl.link_ctrl_plcp, ctrl.delineate_in_plcp,
                ctrl.cell_processing, ctrl.tester_clk_en, ctrl.payload_from_tester,
                ctrl.rx_to_processor, ctrl.port_clk_en});
        end
        wr(12'h108, 16'h0000);
        wr(12'h100, 16'h0000);
        pkt <= 1'b1;
        endt("routing");
        wr(12'h100, 16'h0080);
        pulses(e, l);
        chk("err port", 16'h1, e);
        wr(12'h100, 16'h0040);
        wr(12'h100, 16'h00c0);
        pulses(e, l);
        chk("err masked", 16'h0, e);
        gerr <= 1'b1;
        pulses(e, l);
        chk("err global", 16'h1, e);
        gerr <= 1'b0;
        wr(12'h100, 16'h0008);
        pulses(e, l);
        chk("latch port", 16'h1, l);
        cap <= 1'b1;
        tick(1);
        cap <= 1'b0;
        tick(2);
        rd("latch done", 12'h148, 16'h0001);
        wr(12'h100, 16'h0000);
        rd("latch clear", 12'h148, 16'h0000);
        wr(12'h100, 16'h0010);
        glat <= 1'b1;
        pulses(e, l);
        chk("latch global", 16'h1, l);
        glat <= 1'b0;
        wr(12'h100, 16'h0000);
        endt("strobes");
        wr(12'h100, 16'h0c00);
        wr(12'h108, 16'h0410);
        fl <= 3'h2;
        tick(3);
        chk("line off", 16'h0, {13'h0, tx});
        wr(12'h108, 16'h8410);
        tick(3);
        chk("line pass", 16'h2, {13'h0, tx});
        fl <= 3'h0;
        wr(12'h100, 16'h0400);
        tick(3);
        chk("alarm ones", 16'h1, {15'h0, tx.pos});
        wr(12'h100, 16'h0000);
        lbk <= 3'h4;
        tick(3);
        chk("alarm auto", 16'h1, {15'h0, tx.pos});
        lbk <= 3'h0;
        tick(3);
        chk("auto idle", 16'h0, {15'h0, tx.pos});
        wr(12'h100, 16'h0800);
        tick(2);
        ones(n);
        chk("alarm e3", 16'h0010, n);
        wr(12'h108, 16'h8400);
        tick(2);
        ones(n);
        chk("alarm ds3", 16'h1, {15'h0, n > 0 && n < 16});
        wr(12'h108, 16'h8010);
        tick(2);
        ones(n);
        chk("alarm ami", 16'h1, {15'h0, n > 0 && n < 16});
        wr(12'h100, 16'h0c00);
        wr(12'h108, 16'h0000);
        endt("line");
        wr(12'h100, 16'h0001);
        tick(2);
        rd("port rst ctl", 12'h100, 16'h0007);
        wr(12'h108, 16'h8000);
        rd("port rst mode", 12'h108, 16'h0000);
        rd("port rst stat", 12'h148, 16'h000a);
        chk("port rst out", 16'h1, {15'h0, ctrl.port_reset});
        grst <= 1'b1;
        tick(2);
        grst <= 1'b0;
        tick(4);
        rd("global rst", 12'h100, 16'h0006);
        wr(12'h100, 16'h0000);
        tick(6);
        hwn <= 1'b0;
        tick(4);
        rd("pin rst", 12'h100, 16'h0006);
        hwn <= 1'b1;
        tick(6);
        endt("resets");
        final_report;
    end

    initial
    begin
        repeat (4000) @(posedge clk);
        err_total++;
        final_report;
    end
endmodule

`default_nettype wire
